// ### src/sdbr_burst_read.sv
/*
 * Diagnostic burst-read path of the addressed serial slave: command
 * capture, status and register shifting, clock-count check, comm error.
 * Assumes the serial clock idles low and stops while chip select is high,
 * and that chip select falls well over three system clocks before the
 * first serial clock edge, so the frozen snapshot is stable at the link.
 */
`timescale 1ns/100ps
`default_nettype none

module sdbr_burst_read (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic link_sclk_i,
    input wire logic link_cs_n_i,
    input wire logic link_sdi_i,
    output logic link_sdo_o,
    output logic link_sdo_oe_n_o,
    input wire logic chain_mode_i,
    input wire logic checksum_enable_i,
    input wire logic chip_addr_hi_i,
    input wire logic chip_addr_lo_i,
    input wire sdbr_pkg::sdbr_diag_s diag_i,
    input wire logic supply_fault_bit_i,
    input wire logic thermal_fault_bit_i,
    output logic comm_error_out_o,
    output logic global_fault_bit_o,
    output logic [5:0] read_clear_o
);

    // =====================================================================
    // Helpers
    // Serial check value step, one output bit at a time
    function automatic logic [4:0] crc_step(input logic [4:0] crc,
                                            input logic din);
        logic fb;
        fb = crc[4] ^ din;
        crc_step = {crc[3:0], 1'b0} ^ (fb ? sdbr_pkg::CRC_POLY : 5'h00);
    endfunction : crc_step

    // Saturating clock count step
    function automatic logic [6:0] cnt_inc(input logic [6:0] c);
        cnt_inc = (c == sdbr_pkg::CNT_MAX) ? c : c + 7'h01;
    endfunction : cnt_inc

    // =====================================================================
    // System side: synchronisers and snapshot
    logic [5:0] pin_s1_ff;
    logic [5:0] pin_s2_ff;
    logic cs_s3_ff;
    logic armed_s1_ff;
    logic armed_s2_ff;
    logic comm_err_ff;
    logic [5:0] read_clear_ff;
    sdbr_pkg::sdbr_snap_s snap_ff;

    // Level inputs cross through two flip-flops
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_s1_ff <= 6'h01;
            pin_s2_ff <= 6'h01;
            cs_s3_ff <= 1'b1;
        end else begin
            pin_s1_ff <= {chain_mode_i, checksum_enable_i, chip_addr_hi_i,
                          chip_addr_lo_i, 1'b0, link_cs_n_i};
            pin_s2_ff <= pin_s1_ff;
            cs_s3_ff <= pin_s2_ff[0];
        end
    end

    logic cs_idle;
    logic cs_rise;
    assign cs_idle = pin_s2_ff[0];
    assign cs_rise = pin_s2_ff[0] & ~cs_s3_ff;

    // Global fault bit is the OR of the three global faults
    logic global_fault;
    assign global_fault = comm_err_ff | supply_fault_bit_i
                          | thermal_fault_bit_i;

    // Snapshot refreshes between frames and freezes while selected
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            snap_ff <= sdbr_pkg::SNAP_RESET;
        end else if (cs_idle) begin
            snap_ff <= {diag_i, supply_fault_bit_i, thermal_fault_bit_i,
                        global_fault, pin_s2_ff[5:2]};
        end
    end

    // =====================================================================
    // Link side: rising edge command capture and clock count
    logic armed_ff;
    logic [6:0] cnt_ff;
    logic [7:0] cmd_ff;

    // Armed between frames so the first clock restarts the count
    always_ff @(posedge link_sclk_i or posedge link_cs_n_i) begin
        if (link_cs_n_i) begin
            armed_ff <= 1'b1;
        end else begin
            armed_ff <= 1'b0;
        end
    end

    // Clocks counted from chip select falling; held after the frame
    always_ff @(posedge link_sclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= armed_ff ? 7'h01 : cnt_inc(cnt_ff);
        end
    end

    // Command byte shifts in MSB first on the first eight clocks
    always_ff @(posedge link_sclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmd_ff <= sdbr_pkg::CMD_RESET;
        end else if (armed_ff) begin
            cmd_ff <= {7'h00, link_sdi_i};
        end else if (cnt_ff < sdbr_pkg::CLK_CMD_LAST) begin
            cmd_ff <= {cmd_ff[6:0], link_sdi_i};
        end
    end

    // Address hit kept for the end-of-frame check, since the low end of
    // the command register holds other fields once the byte is complete
    logic addr_hit_ff;
    always_ff @(posedge link_sclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            addr_hit_ff <= 1'b0;
        end else if (armed_ff) begin
            addr_hit_ff <= 1'b0;
        end else if (cnt_ff == 7'h01) begin
            addr_hit_ff <= ({cmd_ff[0], link_sdi_i}
                            == {snap_ff.chip_addr_hi, snap_ff.chip_addr_lo})
                           & ~snap_ff.chain_mode;
        end
    end

    // =====================================================================
    // Link side: falling edge output shifter
    logic [6:0] nclk;
    logic addr_ok_ff;
    logic addr_match;
    logic addr_ok;
    logic burst_rd;
    logic [47:0] data_flat;
    logic [5:0] status;
    logic [2:0] tail;
    logic [4:0] crc_ff;
    logic nxt_bit;
    logic nxt_drive;
    logic [6:0] frame_end;

    assign nclk = cnt_inc(cnt_ff);
    assign data_flat = snap_ff.diag;
    assign addr_match = (cmd_ff[1:0] == {snap_ff.chip_addr_hi,
                        snap_ff.chip_addr_lo}) & ~snap_ff.chain_mode;
    assign addr_ok = (nclk == sdbr_pkg::CLK_STATUS_FIRST) ? addr_match
                                                          : addr_ok_ff;
    assign burst_rd = cmd_ff[sdbr_pkg::CMD_BURST_POS]
                      & ~cmd_ff[sdbr_pkg::CMD_WRITE_POS]
                      & (cmd_ff[4:1] == sdbr_pkg::REG_OVERLOAD);
    assign frame_end = snap_ff.checksum_enable ? sdbr_pkg::CLKS_BURST_CRC
                                               : sdbr_pkg::CLKS_BURST;
    // Status order: short, wire on, wire off, limit, overload, global
    assign status = {|snap_ff.diag.channel_supply_short_flags,
                     |snap_ff.diag.channel_openwire_on_flags,
                     |snap_ff.diag.channel_openwire_off_flags,
                     |snap_ff.diag.channel_current_limit_flags,
                     |snap_ff.diag.channel_overload_flags,
                     snap_ff.comm_fault_bit | snap_ff.supply_fault_bit
                     | snap_ff.thermal_fault_bit};
    assign tail = {cmd_ff[sdbr_pkg::CMD_ADDR_HI_POS],
                   cmd_ff[sdbr_pkg::CMD_ADDR_LO_POS],
                   snap_ff.thermal_fault_bit};

    // Chooses the bit presented for the next clock
    always_comb begin
        nxt_bit = 1'b0;
        nxt_drive = 1'b0;
        if (addr_ok && nclk >= sdbr_pkg::CLK_STATUS_FIRST) begin
            if (nclk <= sdbr_pkg::CLK_STATUS_LAST) begin
                nxt_drive = 1'b1;
                nxt_bit = status[3'(sdbr_pkg::CLK_STATUS_LAST - nclk)];
            end else if (nclk <= sdbr_pkg::CLK_DATA_LAST) begin
                nxt_drive = 1'b1;
                // Six bytes, ascending address, MSB first
                nxt_bit = burst_rd & data_flat[6'(sdbr_pkg::CLK_DATA_LAST
                          - nclk)];
            end else if (burst_rd && nclk <= frame_end) begin
                nxt_drive = 1'b1;
                if (nclk <= sdbr_pkg::CLK_TAIL_LAST) begin
                    nxt_bit = tail[2'(sdbr_pkg::CLK_TAIL_LAST - nclk)];
                end else begin
                    nxt_bit = crc_ff[3'(sdbr_pkg::CLK_CRC_LAST - nclk)];
                end
            end
        end
    end

    // Drives the pin on falling edges; released whenever deselected
    always_ff @(negedge link_sclk_i or posedge link_cs_n_i) begin
        if (link_cs_n_i) begin
            link_sdo_o <= 1'b0;
            link_sdo_oe_n_o <= 1'b1;
            addr_ok_ff <= 1'b0;
        end else begin
            link_sdo_o <= nxt_bit;
            link_sdo_oe_n_o <= ~nxt_drive;
            addr_ok_ff <= addr_ok;
        end
    end

    // Check value over every bit sent before it
    always_ff @(negedge link_sclk_i or posedge link_cs_n_i) begin
        if (link_cs_n_i) begin
            crc_ff <= sdbr_pkg::CRC_INIT;
        end else if (nxt_drive && nclk < sdbr_pkg::CLK_CRC_FIRST) begin
            crc_ff <= crc_step(crc_ff, nxt_bit);
        end
    end

    // =====================================================================
    // System side: end-of-frame check
    logic [6:0] nclks_frame;
    logic [6:0] expect_clks;
    logic frame_for_us;
    logic frame_bad;
    logic frame_burst;

    // Armed flag tells a clockless frame apart from a stale count
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            armed_s1_ff <= 1'b1;
            armed_s2_ff <= 1'b1;
        end else begin
            armed_s1_ff <= armed_ff;
            armed_s2_ff <= armed_s1_ff;
        end
    end

    // A frame saw clocks once the armed flag dropped while still selected;
    // the synced armed flag rises with the synced select and cannot say so
    logic clocked_ff;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            clocked_ff <= 1'b0;
        end else if (cs_rise) begin
            clocked_ff <= 1'b0;
        end else if (!pin_s2_ff[0] && !armed_s2_ff) begin
            clocked_ff <= 1'b1;
        end
    end

    // Count and command are static once chip select is high
    assign nclks_frame = clocked_ff ? cnt_ff : 7'h00;
    assign frame_for_us = (nclks_frame != 7'h00) & addr_hit_ff;
    assign frame_burst = cmd_ff[sdbr_pkg::CMD_BURST_POS]
                         & ~cmd_ff[sdbr_pkg::CMD_WRITE_POS];
    always_comb begin
        if (frame_burst) begin
            expect_clks = frame_end;
        end else if (snap_ff.checksum_enable) begin
            expect_clks = sdbr_pkg::CLKS_SINGLE_CRC;
        end else begin
            expect_clks = sdbr_pkg::CLKS_SINGLE;
        end
    end
    assign frame_bad = (nclks_frame != expect_clks)
                       | (frame_burst & ~burst_rd);

    // Comm error is sticky; a new error wins over the clear
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            comm_err_ff <= 1'b0;
        end else if (cs_rise && frame_for_us && frame_bad) begin
            comm_err_ff <= 1'b1;
        end else if (cs_rise && frame_for_us && burst_rd) begin
            comm_err_ff <= 1'b0;
        end
    end

    // Read-clear pulse for the six registers after a whole burst
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            read_clear_ff <= 6'h00;
        end else if (cs_rise && frame_for_us && !frame_bad && burst_rd) begin
            read_clear_ff <= 6'h3f;
        end else begin
            read_clear_ff <= 6'h00;
        end
    end

    assign comm_error_out_o = comm_err_ff;
    assign global_fault_bit_o = global_fault;
    assign read_clear_o = read_clear_ff;

endmodule : sdbr_burst_read

`default_nettype wire

// ### shared/sdbr_pkg.sv
/*
 * Constants and carrier types for the diagnostic burst-read path of the
 * addressed serial slave.
 * Assumes a mode 0 serial link (sample on rising, shift on falling edge)
 * and diagnostic flag registers kept by logic outside this block.
 */
//
// Function
// - Burst reads are served only while the chain-mode select is low.
// - Only the six diagnostic registers can be read in a burst.
// - One burst frame returns six registers in ascending order, a byte each.
// - Chip select rising before register 9 is fully out raises comm error.
// - Output is high impedance for clocks 1-2, then six global status bits.
// - Register bytes go MSB first, first on clocks 9-16, second on 17-24.
// - A frame whose clock count differs from the expected one is discarded
// - The global fault bit is the OR of comm, supply and thermal faults.
`default_nettype none

package sdbr_pkg;
    // =====================================================================
    // Frame geometry
    localparam int BYTE_BITS = 8;
    localparam int NUM_REGS = 6;
    localparam int CNT_W = 7;
    localparam logic [6:0] CNT_MAX = 7'h7f;
    localparam logic [6:0] CLK_CMD_LAST = 7'h08;
    localparam logic [6:0] CLK_ADDR_LAST = 7'h02;
    localparam logic [6:0] CLK_STATUS_FIRST = 7'h03;
    localparam logic [6:0] CLK_STATUS_LAST = 7'h08;
    localparam logic [6:0] CLK_DATA_FIRST = 7'h09;
    localparam logic [6:0] CLK_DATA_LAST = 7'h38;
    localparam logic [6:0] CLK_TAIL_FIRST = 7'h39;
    localparam logic [6:0] CLK_TAIL_LAST = 7'h3b;
    localparam logic [6:0] CLK_CRC_FIRST = 7'h3c;
    localparam logic [6:0] CLK_CRC_LAST = 7'h40;
    // Expected clock counts per frame kind
    localparam logic [6:0] CLKS_BURST = 7'h38;
    localparam logic [6:0] CLKS_BURST_CRC = 7'h40;
    localparam logic [6:0] CLKS_SINGLE = 7'h10;
    localparam logic [6:0] CLKS_SINGLE_CRC = 7'h18;

    // =====================================================================
    // Command byte fields and register map
    localparam int CMD_ADDR_HI_POS = 7;
    localparam int CMD_ADDR_LO_POS = 6;
    localparam int CMD_BURST_POS = 5;
    localparam int CMD_REG_MSB = 4;
    localparam int CMD_REG_LSB = 1;
    localparam int CMD_WRITE_POS = 0;
    localparam logic [3:0] REG_OVERLOAD = 4'h4;
    localparam logic [3:0] REG_GLOBAL_ERROR = 4'h9;
    localparam logic [7:0] CMD_RESET = 8'h00;

    // =====================================================================
    // Check value
    localparam logic [4:0] CRC_POLY = 5'h05;
    localparam logic [4:0] CRC_INIT = 5'h1f;

    // Diagnostic registers, ascending address order from the top
    typedef struct packed {
        logic [7:0] channel_overload_flags;
        logic [7:0] channel_current_limit_flags;
        logic [7:0] channel_openwire_off_flags;
        logic [7:0] channel_openwire_on_flags;
        logic [7:0] channel_supply_short_flags;
        logic [7:0] global_error_flags;
    } sdbr_diag_s;

    // Frame snapshot handed to the link side, frozen while selected
    typedef struct packed {
        sdbr_diag_s diag;
        logic supply_fault_bit;
        logic thermal_fault_bit;
        logic comm_fault_bit;
        logic chain_mode;
        logic checksum_enable;
        logic chip_addr_hi;
        logic chip_addr_lo;
    } sdbr_snap_s;

    localparam sdbr_snap_s SNAP_RESET = '0;
endpackage : sdbr_pkg

`default_nettype wire

// ### bench/sdbr_burst_read_asserts.sv
/* Concurrent checks on the ports of the diagnostic burst-read path.
   Assumes mode pins stay steady while a frame is in flight. */
`timescale 1ns/100ps
`default_nettype none

module sdbr_burst_read_asserts (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic link_sclk_i,
    input wire logic link_cs_n_i,
    input wire logic link_sdo_o,
    input wire logic link_sdo_oe_n_o,
    input wire logic chain_mode_i,
    input wire logic supply_fault_bit_i,
    input wire logic thermal_fault_bit_i,
    input wire logic comm_error_out_o,
    input wire logic global_fault_bit_o,
    input wire logic [5:0] read_clear_o
);
    // ==================================================================
    // Serial clocks seen so far in the frame
    logic [6:0] edge_cnt_ff;
    always_ff @(posedge link_sclk_i or posedge link_cs_n_i) begin
        if (link_cs_n_i) edge_cnt_ff <= 7'h00;
        else if (edge_cnt_ff != 7'h7f) edge_cnt_ff <= edge_cnt_ff + 7'h01;
    end
    // Clear strobe: all six bits for one cycle
    sequence s_clear_pulse;
        read_clear_o == 6'h3f ##1 read_clear_o == 6'h00;
    endsequence
    // Select went high a short while ago
    sequence s_frame_ended;
        link_cs_n_i && !$past(link_cs_n_i, 8);
    endsequence
    // ==================================================================
    // Assertions
    AST_GLOBAL_OR: assert property (@(posedge clk_i) disable iff (!rstn_i)
        global_fault_bit_o ==
        (comm_error_out_o | supply_fault_bit_i | thermal_fault_bit_i))
        else $error("global fault differs from its sources");
    AST_IDLE_RELEASED: assert property (@(posedge clk_i)
        disable iff (!rstn_i) link_cs_n_i ##1 link_cs_n_i |-> link_sdo_oe_n_o)
        else $error("serial out driven while deselected");
    AST_CHAIN_SILENT: assert property (@(posedge clk_i)
        disable iff (!rstn_i) $fell(link_sdo_oe_n_o) |-> !chain_mode_i)
        else $error("serial out driven in chain mode");
    AST_CLEAR_PULSE: assert property (@(posedge clk_i)
        disable iff (!rstn_i) read_clear_o != 6'h00 |-> s_clear_pulse)
        else $error("read clear strobe malformed");
    AST_CLEAR_AFTER_FRAME: assert property (@(posedge clk_i)
        disable iff (!rstn_i) read_clear_o != 6'h00 |-> s_frame_ended)
        else $error("read clear outside frame end");
    AST_ERR_AFTER_FRAME: assert property (@(posedge clk_i)
        disable iff (!rstn_i) $rose(comm_error_out_o) |-> s_frame_ended)
        else $error("comm error raised outside frame end");
    AST_ERR_CLEARED_BY_READ: assert property (@(posedge clk_i)
        disable iff (!rstn_i)
        $fell(comm_error_out_o) |-> read_clear_o == 6'h3f)
        else $error("comm error cleared without good burst");
    AST_HIZ_FIRST_TWO: assert property (@(posedge link_sclk_i)
        disable iff (!rstn_i) edge_cnt_ff < 7'h02 |-> link_sdo_oe_n_o)
        else $error("serial out driven in first two clocks");
    AST_SDO_HELD: assert property (@(posedge clk_i)
        disable iff (!rstn_i)
        link_sclk_i && $past(link_sclk_i) |-> $stable(link_sdo_o))
        else $error("serial out moved while clock high");
endmodule : sdbr_burst_read_asserts

bind sdbr_burst_read sdbr_burst_read_asserts i_asserts (
    .clk_i(clk_i), .rstn_i(rstn_i), .link_sclk_i(link_sclk_i),
    .link_cs_n_i(link_cs_n_i), .link_sdo_o(link_sdo_o),
    .link_sdo_oe_n_o(link_sdo_oe_n_o), .chain_mode_i(chain_mode_i),
    .supply_fault_bit_i(supply_fault_bit_i),
    .thermal_fault_bit_i(thermal_fault_bit_i),
    .comm_error_out_o(comm_error_out_o),
    .global_fault_bit_o(global_fault_bit_o), .read_clear_o(read_clear_o)
);

`default_nettype wire

// ### bench/sdbr_host_model.sv
/* Host controller model: mode 0 frames on the shared select line.
   Assumes frame() is called only while the select is idle. */
`timescale 1ns/100ps
`default_nettype none

module sdbr_host_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdi_o,
    input wire logic sdo_i,
    input wire logic sdo_oe_n_i
);
    // ==================================================================
    // Captured serial out and enable, one entry per clock
    logic [1:64] got_q;
    logic [1:64] hz_q;
    // Idle bus: clock low and still, select high
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o = 1'b1;
    end
    // One frame of n clocks, command byte first, zeros after it
    task automatic frame(input logic [7:0] cmd, input int n);
        got_q = 'x;
        hz_q = 'x;
        #7 cs_n_o = 1'b0;
        #32;
        for (int k = 1; k <= n; k++) begin
            sdi_o = (k <= 8) ? cmd[8 - k] : 1'b0;
            #32 sclk_o = 1'b1;
            got_q[k] = sdo_i;
            hz_q[k] = sdo_oe_n_i;
            #32 sclk_o = 1'b0;
        end
        #32 cs_n_o = 1'b1;
        sdi_o = ~sdi_o;
    endtask : frame
endmodule : sdbr_host_model

`default_nettype wire

// ### bench/testbench.sv
/* Self-checking bench: a table of frames, then the verdict.
   Assumes sdbr_pkg and sdbr_host_model are compiled first. */
`timescale 1ns/100ps
`default_nettype none

module testbench;
    typedef struct packed {
        logic chain;
        logic crc;
        logic [1:0] adr;
        logic [7:0] cmd;
        logic [6:0] n;
        logic [1:0] flt;
    } sdbr_row_s;
    logic clk_i, rstn_i, sclk, cs_n, sdi, sdo, oe_n, chain, crc, ahi, alo;
    logic sup, thr, err, gf, drive, good, exp_err, fb;
    logic [5:0] rclr;
    logic [1:64] ev;
    logic [4:0] cv;
    sdbr_pkg::sdbr_diag_s diag;
    sdbr_row_s r;
    int fail_count = 0;
    int cmp_count = 0;
    int rc_cnt = 0;
    int rc_old, last;
    // Rows: chain, checksum, strap, command, clocks, supply/thermal
    sdbr_row_s rows [10] = '{
        {1'b0, 1'b0, 2'h1, 8'h68, 7'h38, 2'h0},
        {1'b0, 1'b0, 2'h1, 8'h68, 7'h30, 2'h0},
        {1'b0, 1'b0, 2'h1, 8'ha8, 7'h38, 2'h0},
        {1'b1, 1'b0, 2'h1, 8'h68, 7'h38, 2'h0},
        {1'b0, 1'b1, 2'h1, 8'h68, 7'h40, 2'h1},
        {1'b0, 1'b1, 2'h1, 8'h68, 7'h38, 2'h2},
        {1'b0, 1'b0, 2'h1, 8'h68, 7'h38, 2'h0},
        {1'b0, 1'b0, 2'h1, 8'h48, 7'h10, 2'h0},
        {1'b0, 1'b0, 2'h1, 8'h6a, 7'h38, 2'h0},
        {1'b0, 1'b0, 2'h2, 8'ha8, 7'h38, 2'h0}};

    sdbr_host_model i_host (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi),
        .sdo_i(sdo), .sdo_oe_n_i(oe_n));
    sdbr_burst_read i_dut (.clk_i(clk_i), .rstn_i(rstn_i),
        .link_sclk_i(sclk), .link_cs_n_i(cs_n), .link_sdi_i(sdi),
        .link_sdo_o(sdo), .link_sdo_oe_n_o(oe_n), .chain_mode_i(chain),
        .checksum_enable_i(crc), .chip_addr_hi_i(ahi), .chip_addr_lo_i(alo),
        .diag_i(diag), .supply_fault_bit_i(sup), .thermal_fault_bit_i(thr),
        .comm_error_out_o(err), .global_fault_bit_o(gf),
        .read_clear_o(rclr));

    // ==================================================================
    // Clock, clear-strobe count, compare and verdict
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
        if (rclr === 6'h3f) rc_cnt++;
    task automatic chk(input string nm, input logic [7:0] e,
            input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic tally_and_finish();
        if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    // Watchdog against a hung frame
    initial begin
        #200000;
        fail_count++;
        tally_and_finish();
    end
    // ==================================================================
    // Reset, then one frame per row
    initial begin
        {rstn_i, chain, crc, ahi, alo, sup, thr} = '0;
        diag = 48'h81_42_00_18_a5_7e;
        exp_err = 1'b0;
        repeat (2) @(negedge clk_i);
        chk("oe_n", 8'h01, 8'(oe_n));
        chk("err", 8'h00, 8'(err));
        chk("rclr", 8'h00, 8'(rclr));
        rstn_i = 1'b1;
        foreach (rows[i]) begin
            r = rows[i];
            @(negedge clk_i);
            {chain, crc, ahi, alo, sup, thr} = {r.chain, r.crc, r.adr, r.flt};
            repeat (8) @(negedge clk_i);
            drive = !r.chain && r.cmd[7:6] == r.adr;
            good = r.cmd[5:0] == 6'h28 && r.n == (r.crc ? 7'h40 : 7'h38);
            ev = '0;
            ev[3:8] = {|diag[15:8], |diag[23:16], |diag[31:24],
                |diag[39:32], |diag[47:40], exp_err | sup | thr};
            ev[9:56] = diag;
            ev[57:59] = {r.adr, thr};
            cv = 5'h1f;
            for (int k = 3; k <= 59; k++) begin
                fb = cv[4] ^ ev[k];
                cv = {cv[3:0], 1'b0} ^ (fb ? 5'h05 : 5'h00);
            end
            ev[60:64] = cv;
            rc_old = rc_cnt;
            i_host.frame(r.cmd, int'(r.n));
            repeat (12) @(negedge clk_i);
            last = !drive ? 0 : (r.cmd[5:0] == 6'h28 ? int'(r.n) : 8);
            for (int k = 1; k <= int'(r.n); k++) begin
                chk("oe", 8'(drive && k > 2), 8'(!i_host.hz_q[k]));
                if (k > 2 && k <= last)
                    chk("sdo", 8'(ev[k]), 8'(i_host.got_q[k]));
            end
            if (drive)
                exp_err = r.cmd[5] ? !good :
                    (exp_err | r.n != (r.crc ? 7'h18 : 7'h10));
            chk("err", 8'(exp_err), 8'(err));
            chk("gf", 8'(exp_err | sup | thr), 8'(gf));
            chk("rclr", 8'(drive && good), 8'(rc_cnt - rc_old));
        end
        // Clockless frame is ignored, a short burst raises the error
        i_host.frame(8'ha8, 0);
        repeat (12) @(negedge clk_i);
        chk("err_noclk", 8'(exp_err), 8'(err));
        i_host.frame(8'ha8, 16);
        repeat (12) @(negedge clk_i);
        chk("err_short", 8'h01, 8'(err));
        // Reset in mid-run clears the sticky error
        rstn_i = 1'b0;
        @(negedge clk_i);
        chk("err_rst", 8'h00, 8'(err));
        chk("oe_rst", 8'h01, 8'(oe_n));
        rstn_i = 1'b1;
        repeat (3) @(negedge clk_i);
        chk("rclr_rst", 8'h00, 8'(rclr));
        tally_and_finish();
    end
endmodule : testbench

`default_nettype wire
